// File: logic/cavs_pkg.sv
package cavs_pkg;

    // ==========================================================
    // Clock and time base
    // ==========================================================
    localparam int CLK_PERIOD_NS = 50;
    localparam int NS_PER_US = 1000;
    localparam int CYCLES_PER_US = NS_PER_US / CLK_PERIOD_NS;
    localparam int TICK_W = 8;
    localparam int US_W = 19;
    // Reference warm-up, a plain default
    localparam int REFUP_TIME_US = 4000;

    // ==========================================================
    // Widths and counts
    // ==========================================================
    localparam int CODE_W = 16;
    localparam int RAW_W = 17;
    localparam int CH_W = 5;
    localparam int SEL_W = 4;
    localparam int SLOT_W = 4;
    localparam int NUM_CONV = 3;
    localparam int NUM_CELLS = 18;
    localparam int CELLS_PER_CONV = 6;
    localparam int NUM_AUX = 10;
    localparam int NUM_GPIO = 9;

    // ==========================================================
    // Channel codes on the converter select outputs
    // ==========================================================
    localparam logic [CH_W-1:0] CH_NONE = 5'h00;
    localparam logic [CH_W-1:0] CH_CELL_FIRST = 5'h01;
    localparam logic [CH_W-1:0] CH_GPIO_FIRST = 5'h13;
    localparam logic [CH_W-1:0] CH_REF2 = 5'h1C;
    localparam logic [CH_W-1:0] GPIO_BEFORE_REF = 5'h05;
    localparam logic [3:0] AUX_IDX_REF = 4'h9;

    // ==========================================================
    // Channel select field values
    // ==========================================================
    localparam logic [SEL_W-1:0] SEL_ALL = 4'h0;
    localparam logic [SEL_W-1:0] SEL_AUX_REF = 4'hA;

    // ==========================================================
    // Result codes
    // ==========================================================
    localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [CODE_W-1:0] FAULT_BASE = 16'hFF00;
    localparam logic [1:0] PS_LAST_CHECKED = 2'h1;

    // ==========================================================
    // Commands and timing per mode
    // ==========================================================
    typedef enum logic [1:0] {
        CMD_CELL,
        CMD_AUX,
        CMD_AUX_CHECKED,
        CMD_CELL_AUX
    } cavs_cmd_t;

    typedef struct packed {
        logic [US_W-1:0] t_first;
        logic [US_W-1:0] t_step;
        logic [US_W-1:0] t_cell_all;
        logic [US_W-1:0] t_cell_one;
        logic [US_W-1:0] t_aux_all;
        logic [US_W-1:0] t_cva_all;
    } cavs_timing_t;

    // Index is {converter_option_bit, oversampling_mode_field}
    localparam cavs_timing_t TIMING_TABLE [8] = '{
        '{19'd1890, 19'd1880, 19'd12816, 19'd2152, 19'd21316, 19'd17104},
        '{19'd58, 19'd46, 19'd1121, 19'd203, 19'd1825, 19'd1511},
        '{19'd145, 19'd134, 19'd2343, 19'd407, 19'd3862, 19'd3140},
        '{19'd29818, 19'd29806, 19'd201325, 19'd33570, 19'd335498, 19'd260937},
        '{19'd960, 19'd948, 19'd7230, 19'd1221, 19'd12007, 19'd9657},
        '{19'd87, 19'd76, 19'd1296, 19'd232, 19'd2116, 19'd1744},
        '{19'd261, 19'd251, 19'd3041, 19'd523, 19'd5025, 19'd4071},
        '{19'd494, 19'd483, 19'd4437, 19'd756, 19'd7353, 19'd5933}
    };

endpackage

// File: logic/cavs_fmt_if.sv
`timescale 1ns/1ps
interface cavs_fmt_if;
    import cavs_pkg::*;
    logic signed [RAW_W-1:0] raw;
    logic signed [RAW_W-1:0] red_raw;
    logic check_en;
    logic [CODE_W-1:0] ov_thr;
    logic [CODE_W-1:0] uv_thr;
    logic [CODE_W-1:0] code;
    logic ov;
    logic uv;

    modport fmt (
        input raw,
        input red_raw,
        input check_en,
        input ov_thr,
        input uv_thr,
        output code,
        output ov,
        output uv
    );
    modport seq (
        output raw,
        output red_raw,
        output check_en,
        output ov_thr,
        output uv_thr,
        input code,
        input ov,
        input uv
    );
endinterface

// File: logic/cavs_result_fmt.sv
`timescale 1ns/1ps
module cavs_result_fmt (
    cavs_fmt_if.fmt bus
);
    import cavs_pkg::*;

    // ==========================================================
    // Clamp to the unsigned 100 uV code
    // ==========================================================
    function automatic logic [CODE_W-1:0] clamp(input logic signed [RAW_W-1:0] v);
        logic [CODE_W-1:0] r;
        r = CODE_ZERO;
        if (!v[RAW_W-1]) begin
            r = v[CODE_W-1:0]; // R1
        end
        return r; // R2
    endfunction

    wire [CODE_W-1:0] primary = clamp(bus.raw);
    wire [CODE_W-1:0] redundant = clamp(bus.red_raw);
    wire [3:0] nibble_bad;

    genvar n;
    generate
        for (n = 0; n < 4; n++) begin : g_nib
            assign nibble_bad[n] = primary[4*n+3 -: 4] != redundant[4*n+3 -: 4];
        end
    endgenerate

    // Fault code is FAULT_BASE ORed with the nibble mismatch mask; it falls inside the clamp range
    wire fault = bus.check_en && (nibble_bad != 4'h0); // R15
    assign bus.code = fault ? (FAULT_BASE | {12'h000, nibble_bad}) : primary; // R15
    assign bus.ov = primary > bus.ov_thr; // R8
    assign bus.uv = primary < bus.uv_thr; // R9

endmodule // cavs_result_fmt

// File: logic/cavs_sequencer.sv
// Functional notes
// R1: Results are unsigned 16-bit codes, one step per 100 microvolts.
// R2: Negative readings are clamped to the zero code.
// R3: Cell command measures cell inputs; options pick channels and converter mode.
// R4: All cells: each converter walks its own six cells, all in parallel.
// R5: A calibration pass follows measurement; command ends when it ends.
// R6: All-cell totals: 1,121 fast, 2343 normal, 201,325 filtered microseconds.
// R7: Three-cell conversion: 203 fast, 407 normal microseconds, calibration included.
// R8: Each cell result above the overvoltage threshold sets its flag.
// R9: Each cell result below the undervoltage threshold sets its flag.
// R10: Thresholds come from configuration inputs; flags go to status outputs.
// R11: Aux command picks one input, the reference alone, or all ten.
// R12: Full aux sequence runs all ten measurements on converter one only.
// R13: Second reference is converted right after input five, before six.
// R14: Full aux totals: 1825 fast, 3862 normal microseconds.
// R15: Checked aux command does plain aux conversions plus a redundant check.
// R16: Host sets the path select to 0 or 1 for the check.
// R17: Checked aux command takes exactly as long as plain aux.
// R18: Combined command converts all cells plus inputs one and two.
// R19: Combined command totals: 1511 fast, 3140 normal microseconds.
// R20: In fast mode current-to-voltage sample skew stays within 194 microseconds.
// R21: Option bit with the two-bit mode field selects one of eight modes.
// R22: Reference off at command: wait startup delay first; kept on: no wait.
// R23: Busy shows from command acceptance until calibration ends.
`timescale 1ns/1ps
module cavs_sequencer #(
    parameter int TICK_CYCLES = cavs_pkg::CYCLES_PER_US,
    parameter int REFUP_US = cavs_pkg::REFUP_TIME_US
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire cavs_pkg::cavs_cmd_t cmd_type,
    input wire logic [cavs_pkg::SEL_W-1:0] chan_select,
    input wire logic [1:0] oversampling_mode_field,
    input wire logic converter_option_bit,
    input wire logic reference_keep_on,
    input wire logic [1:0] redundancy_path_select,
    input wire logic [cavs_pkg::CODE_W-1:0] ov_threshold,
    input wire logic [cavs_pkg::CODE_W-1:0] uv_threshold,
    input wire logic signed [cavs_pkg::RAW_W-1:0] adc_raw [cavs_pkg::NUM_CONV],
    input wire logic signed [cavs_pkg::RAW_W-1:0] redundant_raw,
    output logic [cavs_pkg::CH_W-1:0] adc_chan [cavs_pkg::NUM_CONV],
    output logic busy,
    output logic cal_active,
    output logic done,
    output logic reference_on,
    output logic [cavs_pkg::NUM_CELLS-1:0][cavs_pkg::CODE_W-1:0] cell_results,
    output logic [cavs_pkg::NUM_AUX-1:0][cavs_pkg::CODE_W-1:0] aux_results,
    output logic [cavs_pkg::NUM_CELLS-1:0] ov_flags,
    output logic [cavs_pkg::NUM_CELLS-1:0] uv_flags
);
    import cavs_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE,
        S_REF,
        S_MEAS,
        S_CAL
    } cavs_state_t;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [US_W-1:0] REFUP_LAST = US_W'(REFUP_US - 1);

    // ==========================================================
    // Slot plan helpers
    // ==========================================================
    function automatic logic [CH_W-1:0] aux_chan(input logic [3:0] idx);
        logic [CH_W-1:0] r;
        r = CH_GPIO_FIRST + CH_W'(idx);
        if (idx == AUX_IDX_REF) begin
            r = CH_REF2;
        end
        return r;
    endfunction

    // Full aux order: inputs one to five, reference, inputs six to nine
    function automatic logic [3:0] aux_slot_idx(input logic [SLOT_W-1:0] slot);
        logic [3:0] r;
        r = 4'(slot);
        if (slot == SLOT_W'(GPIO_BEFORE_REF)) begin
            r = AUX_IDX_REF; // R13
        end else if (slot > SLOT_W'(GPIO_BEFORE_REF)) begin
            r = 4'(slot - 4'h1); // R13
        end
        return r;
    endfunction

    function automatic logic aux_is_all(input logic [SEL_W-1:0] sel);
        return (sel == SEL_ALL) || (sel > SEL_AUX_REF);
    endfunction

    function automatic logic [CH_W-1:0] cell_chan(input logic [1:0] conv,
                                                   input logic [SLOT_W-1:0] step);
        return CH_CELL_FIRST + CH_W'(conv) * CH_W'(CELLS_PER_CONV) + CH_W'(step);
    endfunction

    function automatic logic [CH_W-1:0] slot_chan(input cavs_cmd_t cmd,
                                                   input logic [SEL_W-1:0] sel,
                                                   input logic [SLOT_W-1:0] slot,
                                                   input logic [1:0] conv);
        logic [CH_W-1:0] r;
        r = CH_NONE;
        case (cmd)
            CMD_CELL: begin
                if (sel == SEL_ALL) begin
                    r = cell_chan(conv, slot); // R4
                end else if (sel <= SEL_W'(CELLS_PER_CONV)) begin
                    r = cell_chan(conv, SLOT_W'(sel - 4'h1)); // R3
                end
            end
            CMD_AUX, CMD_AUX_CHECKED: begin
                if (conv == 2'h0) begin
                    if (aux_is_all(sel)) begin
                        r = aux_chan(aux_slot_idx(slot)); // R12
                    end else begin
                        r = aux_chan(4'(sel - 4'h1)); // R11
                    end
                end
            end
            CMD_CELL_AUX: begin
                // Inputs one and two sit mid and end so current is near each cell
                if (slot == 4'h3) begin
                    r = (conv == 2'h0) ? CH_GPIO_FIRST : CH_NONE; // R20
                end else if (slot == 4'h7) begin
                    r = (conv == 2'h0) ? CH_GPIO_FIRST + 5'h01 : CH_NONE; // R18
                end else if (slot < 4'h3) begin
                    r = cell_chan(conv, slot); // R18
                end else begin
                    r = cell_chan(conv, slot - 4'h1); // R18
                end
            end
            default: r = CH_NONE;
        endcase
        return r;
    endfunction

    function automatic logic [SLOT_W-1:0] slot_count(input cavs_cmd_t cmd,
                                                      input logic [SEL_W-1:0] sel);
        logic [SLOT_W-1:0] r;
        r = 4'h1;
        case (cmd)
            CMD_CELL: r = (sel == SEL_ALL) ? SLOT_W'(CELLS_PER_CONV) : 4'h1;
            CMD_AUX, CMD_AUX_CHECKED: r = aux_is_all(sel) ? SLOT_W'(NUM_AUX) : 4'h1;
            CMD_CELL_AUX: r = 4'h8;
            default: r = 4'h1;
        endcase
        return r;
    endfunction

    function automatic logic [US_W-1:0] total_time(input cavs_cmd_t cmd,
                                                    input logic [SEL_W-1:0] sel,
                                                    input cavs_timing_t t);
        logic [US_W-1:0] r;
        r = t.t_cell_one;
        case (cmd)
            CMD_CELL: r = (sel == SEL_ALL) ? t.t_cell_all : t.t_cell_one; // R6 R7
            // Checked and plain aux share one timing entry
            CMD_AUX, CMD_AUX_CHECKED: r = aux_is_all(sel) ? t.t_aux_all : t.t_cell_one; // R14 R17
            CMD_CELL_AUX: r = t.t_cva_all; // R19
            default: r = t.t_cell_one;
        endcase
        return r;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    cavs_state_t state;
    cavs_state_t next_state;
    cavs_cmd_t cmd_q;
    logic [SEL_W-1:0] sel_q;
    logic [2:0] mode_q;
    logic check_q;
    logic [TICK_W-1:0] tick_cnt;
    logic [US_W-1:0] elapsed_us;
    logic [US_W-1:0] sample_at;
    logic [SLOT_W-1:0] slot_q;
    logic [US_W-1:0] ref_cnt;
    logic ref_ready;

    // ==========================================================
    // Decode
    // ==========================================================
    wire cavs_timing_t timing = TIMING_TABLE[mode_q];
    wire [2:0] mode_in = {converter_option_bit, oversampling_mode_field}; // R21
    wire accept = (state == S_IDLE) && cmd_valid; // R23
    wire start_meas = ((state == S_IDLE) && cmd_valid && ref_ready) ||
                      ((state == S_REF) && ref_ready); // R22
    wire tick = tick_cnt == TICK_LAST;
    wire [US_W-1:0] elapsed_inc = elapsed_us + 19'h0_0001;
    wire sample_hit = (state == S_MEAS) && tick && (elapsed_inc == sample_at);
    wire last_slot = slot_q == slot_count(cmd_q, sel_q) - 4'h1;
    wire [US_W-1:0] end_time = total_time(cmd_q, sel_q, timing);
    wire end_hit = (state == S_CAL) && tick && (elapsed_inc == end_time); // R5
    wire ref_needed = reference_keep_on || cmd_valid || (state != S_IDLE);
    wire ref_release = (state == S_IDLE) && !reference_keep_on && !cmd_valid;
    wire ref_done = tick && (ref_cnt == REFUP_LAST);
    // Command fields seen at the accept edge, before the holding registers load
    wire cavs_cmd_t cmd_eff = cavs_cmd_t'(accept ? cmd_type : cmd_q);
    wire [SEL_W-1:0] sel_eff = accept ? chan_select : sel_q;
    wire cavs_timing_t start_timing = TIMING_TABLE[accept ? mode_in : mode_q];
    wire [SLOT_W-1:0] slot_next = start_meas ? 4'h0 : slot_q + (sample_hit ? 4'h1 : 4'h0);
    wire [CH_W-1:0] chan_now [NUM_CONV];
    wire [CODE_W-1:0] conv_code [NUM_CONV];
    wire conv_ov [NUM_CONV];
    wire conv_uv [NUM_CONV];

    // ==========================================================
    // Result formatting, one per converter
    // ==========================================================
    genvar k;
    generate
        for (k = 0; k < NUM_CONV; k++) begin : g_conv
            cavs_fmt_if fmt_bus ();
            assign chan_now[k] = slot_chan(cmd_q, sel_q, slot_q, 2'(k));
            assign fmt_bus.raw = adc_raw[k];
            assign fmt_bus.red_raw = redundant_raw;
            // Single redundant path, applied to converter one only
            assign fmt_bus.check_en = (k == 0) && check_q; // R15
            assign fmt_bus.ov_thr = ov_threshold; // R10
            assign fmt_bus.uv_thr = uv_threshold; // R10
            assign conv_code[k] = fmt_bus.code;
            assign conv_ov[k] = fmt_bus.ov;
            assign conv_uv[k] = fmt_bus.uv;
            cavs_result_fmt u_fmt (
                .bus(fmt_bus)
            );
        end
    endgenerate

    // ==========================================================
    // Sequence control
    // ==========================================================
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (cmd_valid) begin
                    next_state = ref_ready ? S_MEAS : S_REF; // R22
                end
            end
            S_REF: begin
                if (ref_ready) begin
                    next_state = S_MEAS;
                end
            end
            S_MEAS: begin
                if (sample_hit && last_slot) begin
                    next_state = S_CAL; // R5
                end
            end
            S_CAL: begin
                if (end_hit) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_IDLE;
            busy <= 1'b0;
            cal_active <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            busy <= next_state != S_IDLE; // R23
            cal_active <= next_state == S_CAL;
            done <= end_hit;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_q <= CMD_CELL;
            sel_q <= SEL_ALL;
            mode_q <= 3'h0;
            check_q <= 1'b0;
        end else if (accept) begin
            cmd_q <= cmd_type; // R3
            sel_q <= chan_select; // R11
            mode_q <= mode_in; // R21
            check_q <= (cmd_type == CMD_AUX_CHECKED) &&
                       (redundancy_path_select <= PS_LAST_CHECKED); // R16
        end
    end

    // Time base restarts with each measurement so slot edges line up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
            elapsed_us <= '0;
        end else begin
            tick_cnt <= (start_meas || tick) ? '0 : tick_cnt + 8'h01;
            if (start_meas) begin
                elapsed_us <= '0;
            end else if (tick) begin
                elapsed_us <= elapsed_inc;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_q <= '0;
            sample_at <= '0;
        end else if (start_meas) begin
            slot_q <= '0;
            sample_at <= start_timing.t_first;
        end else if (sample_hit) begin
            slot_q <= slot_q + 4'h1;
            sample_at <= sample_at + timing.t_step;
        end
    end

    // ==========================================================
    // Reference warm-up
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_cnt <= '0;
            ref_ready <= 1'b0;
            reference_on <= 1'b0;
        end else begin
            if (ref_release) begin
                ref_cnt <= '0;
                ref_ready <= 1'b0;
            end else if (ref_needed && !ref_ready && tick) begin
                ref_cnt <= ref_cnt + 19'h0_0001;
                ref_ready <= ref_done; // R22
            end
            reference_on <= ref_ready;
        end
    end

    // ==========================================================
    // Converter select and result store
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NUM_CONV; c++) begin
                adc_chan[c] <= CH_NONE;
            end
        end else begin
            for (int c = 0; c < NUM_CONV; c++) begin
                adc_chan[c] <= (next_state == S_MEAS && !(sample_hit && last_slot)) ?
                               slot_chan(cmd_eff, sel_eff, slot_next, 2'(c)) : CH_NONE;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cell_results <= '0;
            aux_results <= '0;
            ov_flags <= '0;
            uv_flags <= '0;
        end else if (sample_hit) begin
            for (int c = 0; c < NUM_CONV; c++) begin
                if (chan_now[c] != CH_NONE && chan_now[c] < CH_GPIO_FIRST) begin
                    cell_results[chan_now[c] - CH_CELL_FIRST] <= conv_code[c]; // R1
                    ov_flags[chan_now[c] - CH_CELL_FIRST] <= conv_ov[c]; // R8 R10
                    uv_flags[chan_now[c] - CH_CELL_FIRST] <= conv_uv[c]; // R9 R10
                end else if (chan_now[c] >= CH_GPIO_FIRST) begin
                    aux_results[chan_now[c] - CH_GPIO_FIRST] <= conv_code[c]; // R1
                end
            end
        end
    end

endmodule // cavs_sequencer

// File: testbench/cavs_seq_properties.sv
`timescale 1ns/1ps
module cavs_seq_properties
    import cavs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [cavs_pkg::CH_W-1:0] adc_chan [cavs_pkg::NUM_CONV],
    input wire logic busy,
    input wire logic cal_active,
    input wire logic done
);
    // ==========================================================
    // Command life cycle
    // ==========================================================
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_accept;
        cmd_valid && !busy && !done;
    endsequence
    sequence s_cal_end;
        cal_active ##1 !cal_active;
    endsequence
    property p_accept;
        s_accept |=> busy;
    endproperty
    property p_cal_end;
        s_cal_end |-> done && !busy;
    endproperty
    property p_done_cause;
        done |-> $past(cal_active);
    endproperty
    property p_done_pulse;
        done |=> !done;
    endproperty
    property p_done_idle;
        done |-> !busy;
    endproperty
    property p_busy_hold;
        busy |=> busy || done;
    endproperty
    property p_cal_chan;
        cal_active |-> busy && adc_chan[0] == CH_NONE && adc_chan[1] == CH_NONE;
    endproperty
    property p_idle_chan;
        !busy |-> adc_chan[0] == CH_NONE && adc_chan[1] == CH_NONE && adc_chan[2] == CH_NONE;
    endproperty
    a_accept: assert property (p_accept) else $error("no busy after accept");
    a_cal_end: assert property (p_cal_end) else $error("no done at end of cal");
    a_done_cause: assert property (p_done_cause) else $error("done without cal");
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    a_done_idle: assert property (p_done_idle) else $error("busy with done");
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    a_cal_chan: assert property (p_cal_chan) else $error("channel during cal");
    a_idle_chan: assert property (p_idle_chan) else $error("channel while idle");
endmodule // cavs_seq_properties

bind cavs_sequencer cavs_seq_properties u_props (.clk(clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .adc_chan(adc_chan), .busy(busy), .cal_active(cal_active),
    .done(done));

// File: testbench/cavs_adc_model.sv
`timescale 1ns/1ps
module cavs_adc_model (
    input wire logic [cavs_pkg::CH_W-1:0] adc_chan [cavs_pkg::NUM_CONV],
    input wire logic corrupt,
    output logic signed [cavs_pkg::RAW_W-1:0] adc_raw [cavs_pkg::NUM_CONV],
    output logic signed [cavs_pkg::RAW_W-1:0] redundant_raw
);
    import cavs_pkg::*;
    // ==========================================================
    // Reading per channel; low channels go negative on purpose
    // ==========================================================
    always_comb begin
        for (int c = 0; c < NUM_CONV; c++) begin
            adc_raw[c] = RAW_W'(int'(adc_chan[c]) * 1000 - 2500);
        end
        redundant_raw = adc_raw[0] ^ (corrupt ? 17'h0_0010 : 17'h0_0000);
    end
endmodule // cavs_adc_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import cavs_pkg::*;
    logic clk, arst_n, cmd_valid, opt, bad, busy, cal, done, ref_on, keep_on;
    cavs_cmd_t cmd_type;
    logic [SEL_W-1:0] sel;
    logic [1:0] md, ps;
    logic signed [RAW_W-1:0] raw [NUM_CONV];
    logic signed [RAW_W-1:0] red;
    logic [CH_W-1:0] chan [NUM_CONV];
    logic [NUM_CELLS-1:0][CODE_W-1:0] cells;
    logic [NUM_AUX-1:0][CODE_W-1:0] aux;
    logic [NUM_CELLS-1:0] ov, uv;
    int n_fail = 0;
    int compares = 0;
    int last_n, plain_n;
    cavs_sequencer #(.TICK_CYCLES(1), .REFUP_US(5)) uut (.clk(clk), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_type(cmd_type), .chan_select(sel),
        .oversampling_mode_field(md), .converter_option_bit(opt), .reference_keep_on(keep_on),
        .redundancy_path_select(ps), .ov_threshold(16'h2710), .uv_threshold(16'h03E8),
        .adc_raw(raw), .redundant_raw(red), .adc_chan(chan), .busy(busy), .cal_active(cal),
        .done(done), .reference_on(ref_on), .cell_results(cells), .aux_results(aux),
        .ov_flags(ov), .uv_flags(uv));
    cavs_adc_model u_model (.adc_chan(chan), .corrupt(bad), .adc_raw(raw), .redundant_raw(red));
    // ==========================================================
    // Helpers
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    function automatic logic [CODE_W-1:0] code_of(input int ch);
        int v;
        v = ch * 1000 - 2500;
        return (v < 0) ? CODE_ZERO : CODE_W'(v);
    endfunction
    // Tick of one cycle per us, so durations are in cycles; one cycle of slack
    task automatic run(input cavs_cmd_t t, input logic [3:0] s, input logic [2:0] m,
                       input int exp_us);
        @(negedge clk);
        cmd_type = t;
        sel = s;
        {opt, md} = m;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        last_n = 0;
        while (done !== 1'b1 && last_n < 400000) begin
            @(negedge clk);
            last_n++;
        end
        if (exp_us > 0) check("duration", 32'(last_n >= exp_us && last_n <= exp_us + 1), 32'h1);
    endtask
    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        #(40_000 * 50);
        n_fail++;
        finish_test();
    end
    initial begin
        arst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_type = CMD_CELL;
        sel = SEL_ALL;
        {opt, md} = 3'h1;
        ps = 2'h0;
        bad = 1'b0;
        keep_on = 1'b1;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        run(CMD_AUX, 4'h1, 3'h1, 0);
        check("warm", 32'(last_n >= 207 && last_n <= 208), 32'h1);
        check("ref_on", ref_on, 1'b1);
        check("general_input_one", aux[0], code_of(19));
        run(CMD_AUX, 4'h1, 3'h1, 203);
        keep_on = 1'b0;
        repeat (2) @(negedge clk);
        check("ref_off", ref_on, 1'b0);
        run(CMD_AUX, 4'h1, 3'h1, 208);
        keep_on = 1'b1;
        run(CMD_CELL, SEL_ALL, 3'h1, 1121);
        for (int i = 0; i < NUM_CELLS; i++) begin
            check("cell", cells[i], code_of(i + 1));
        end
        check("ov", ov, 18'h3_F000);
        check("uv", uv, 18'h0_0007);
        run(CMD_CELL, SEL_ALL, 3'h2, 2343);
        run(CMD_CELL, 4'h1, 3'h1, 203);
        run(CMD_CELL, 4'h1, 3'h2, 407);
        run(CMD_CELL, 4'h1, 3'h5, 232);
        run(CMD_AUX, SEL_ALL, 3'h2, 3862);
        run(CMD_AUX, SEL_ALL, 3'h1, 1825);
        plain_n = last_n;
        for (int i = 0; i < NUM_AUX; i++) begin
            check("aux", aux[i], code_of(i == 9 ? 28 : 19 + i));
        end
        bad = 1'b1;
        run(CMD_AUX_CHECKED, SEL_ALL, 3'h1, 1825);
        check("checked_time", last_n, plain_n);
        check("checked", aux[4], FAULT_BASE | 16'h0002);
        run(CMD_CELL_AUX, SEL_ALL, 3'h1, 1511);
        check("cva_general_input_one", aux[0], code_of(19));
        check("general_input_two", aux[1], code_of(20));
        check("gpio3", aux[2], FAULT_BASE | 16'h0002);
        run(CMD_AUX, 4'hA, 3'h1, 203);
        check("ref2", aux[9], code_of(28));
        ps = 2'h2;
        run(CMD_AUX_CHECKED, SEL_ALL, 3'h1, 1825);
        check("unchecked", aux[4], code_of(23));
        run(CMD_CELL_AUX, SEL_ALL, 3'h2, 3140);
        finish_test();
    end
endmodule // tb
